// *** design/cmrs_clock_top.sv ***
// clock mode and ratio select: source choice, bus clock pin, main
// PLL tick model, core and peripheral dividers, Wishbone registers
// assumes all pins are synchronous to sys_clk and source clocks run
// well below it, so every source edge is seen
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
module cmrs_clock_top
  import cmrs_pkg::*;
(
  // clock and resets
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic manual_rst_n,
  // mode straps
  input wire logic clock_mode_pin_0,
  input wire logic clock_mode_pin_1,
  input wire logic clock_mode_pin_2,
  // clock sources
  input wire logic external_clock_input,
  input wire logic crystal_osc_input,
  // bus clock pin
  input wire logic bus_clock_pin_i,
  output logic bus_clock_pin_o,
  output logic bus_clock_pin_oe,
  // generated clock enables
  output logic main_pll_tick,
  output logic core_clk_en,
  output logic periph_clk_en,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o
);
  // ==========================================================
  // declarations
  logic [2:0] mode_q;
  logic drive_mode;
  logic src_lvl;
  logic shaped_q;
  logic bus_lvl_q;
  logic bus_prev_q;
  logic bus_edge;
  logic [PERIOD_W-1:0] cnt_q;
  logic [PERIOD_W-1:0] cnt_inc;
  logic [PERIOD_W-1:0] period_q;
  logic valid_q;
  logic [PERIOD_W:0] acc_q;
  logic [PERIOD_W:0] acc_sum;
  logic [PERIOD_W:0] acc_d;
  logic pll_tick_d;
  logic [15:0] ctrl;
  logic [15:0] cmrs_ctrl_q;
  cmrs_ratio_t mult;
  logic [7:0] status;
  logic mode_bad;
  logic set_bad;
  logic req;
  logic hit_ctrl;
  logic hit_stat;
  logic ack_q;
  logic err_q;
  logic [31:0] dat_q;
  logic wr_en;
  logic [3:0] hp_ticks_q;
  logic hp_steady_q;
  cmrs_ratio_t mult_q;

  cmrs_tick_if core_if ();
  cmrs_tick_if per_if ();

  // ==========================================================
  // mode straps and source selection
  // straps are static levels; register them once per clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 3'h0;
    end else begin
      mode_q <= {clock_mode_pin_2, clock_mode_pin_1, clock_mode_pin_0};
    end
  end

  // unsupported strap codes are only flagged, behaviour as mode 0
  assign mode_bad = mode_q != MODE_EXT && mode_q != MODE_XTAL
    && mode_q != MODE_PIN;
  assign drive_mode = mode_q != MODE_PIN;
  assign src_lvl = (mode_q == MODE_XTAL) ? crystal_osc_input
    : external_clock_input;

  // input-shaping PLL at ratio 1, held off in mode 7
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shaped_q <= 1'b0;
    end else begin
      shaped_q <= drive_mode ? src_lvl : 1'b0;
    end
  end

  // ==========================================================
  // bus clock pin
  // driven out in modes 0 and 2, input in mode 7
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_clock_pin_o <= 1'b0;
      bus_clock_pin_oe <= 1'b0;
    end else begin
      bus_clock_pin_o <= shaped_q;
      bus_clock_pin_oe <= drive_mode;
    end
  end

  // bus clock level as the main PLL sees it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_lvl_q <= 1'b0;
      bus_prev_q <= 1'b0;
    end else begin
      bus_lvl_q <= drive_mode ? shaped_q : bus_clock_pin_i;
      bus_prev_q <= bus_lvl_q;
    end
  end

  assign bus_edge = bus_lvl_q & ~bus_prev_q;

  // ==========================================================
  // main PLL model: measure the bus period, spread mult ticks in it
  assign cnt_inc = (cnt_q == PERIOD_MAX) ? cnt_q : cnt_q + 16'h0001;

  // period of the bus clock in system cycles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      period_q <= 16'h0000;
      valid_q <= 1'b0;
    end else if (!manual_rst_n) begin
      cnt_q <= 16'h0000;
      valid_q <= 1'b0;
    end else if (bus_edge) begin
      cnt_q <= 16'h0000;
      period_q <= cnt_inc;
      valid_q <= cnt_inc >= PERIOD_MIN && cnt_inc != PERIOD_MAX;
    end else begin
      cnt_q <= cnt_inc;
      if (cnt_q == PERIOD_MAX) begin
        valid_q <= 1'b0; // bus clock stopped
      end
    end
  end

  assign ctrl = cmrs_ctrl_q;
  assign mult = cmrs_ratio(cmrs_field(ctrl, MULT_HI, MULT_MID,
    MULT_LO));

  // tick phase aligned to the bus edge, mult ticks per bus period
  always_comb begin
    acc_sum = acc_q + {{(PERIOD_W-2){1'b0}}, mult};
    acc_d = acc_sum;
    pll_tick_d = 1'b0;
    if (bus_edge) begin
      acc_d = '0;
      pll_tick_d = 1'b1;
    end else if (valid_q && acc_sum >= {1'b0, period_q}) begin
      acc_d = acc_sum - {1'b0, period_q};
      pll_tick_d = 1'b1;
    end
  end

  // main PLL stays on in every supported mode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      main_pll_tick <= 1'b0;
    end else if (!manual_rst_n) begin
      acc_q <= '0;
      main_pll_tick <= 1'b0;
    end else begin
      acc_q <= acc_d;
      main_pll_tick <= pll_tick_d;
    end
  end

  // ==========================================================
  // dividers, both fed from the main PLL tick
  assign core_if.tick = main_pll_tick;
  assign core_if.clr = !manual_rst_n;
  assign core_if.code = cmrs_field(ctrl, CORE_HI, CORE_MID,
    CORE_LO);
  assign per_if.tick = main_pll_tick;
  assign per_if.clr = !manual_rst_n;
  assign per_if.code = cmrs_field(ctrl, PER_HI, PER_MID,
    PER_LO);

  cmrs_ratio_div u_core_div (
    .sys_clk (sys_clk),
    .rst_n (rst_n),
    .t (core_if.div)
  );

  cmrs_ratio_div u_per_div (
    .sys_clk (sys_clk),
    .rst_n (rst_n),
    .t (per_if.div)
  );

  assign core_clk_en = core_if.en;
  assign periph_clk_en = per_if.en;

  // ==========================================================
  // register file

  cmrs_freq_reg u_freq_reg (
    .sys_clk (sys_clk),
    .rst_n (rst_n),
    .wr_en (wr_en),
    .wr_data (wb_dat_i[15:0]),
    .value_q (cmrs_ctrl_q)
  );

  // flags values off the list or past the limits; undefined peripheral codes skip limits
  always_comb begin
    logic [2:0] cd;
    logic [2:0] pd;
    cd = cmrs_ratio(core_if.code);
    pd = cmrs_ratio(per_if.code);
    set_bad = !cmrs_legal(mode_q, ctrl)
      || ((pd != 3'h1 || per_if.code == CODE_X1) && (mult < cd
      || mult > pd
      || {2'h0, pd} > {2'h0, cd} * 5'h06));
  end

  // status word
  always_comb begin
    status = 8'h00;
    status[ST_MODE_LO +: 3] = mode_q;
    status[ST_MODE_BAD] = mode_bad;
    status[ST_SET_BAD] = set_bad;
    status[ST_SHAPE_ON] = drive_mode;
    status[ST_PIN_OUT] = bus_clock_pin_oe;
    status[ST_LOCKED] = valid_q;
  end

  // address decode
  assign hit_ctrl = wb_adr_i[31:2] == FREQ_CTRL_ADDR[31:2];
  assign hit_stat = wb_adr_i[31:2] == CLK_STATUS_ADDR[31:2];
  assign req = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
  // writes need byte lanes 0 and 1 enabled, taken at the edge that samples ack
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & hit_ctrl
    & (&wb_sel_i[1:0]);

  // one answer per access, one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= req & (hit_ctrl | hit_stat);
      err_q <= req & ~(hit_ctrl | hit_stat);
    end
  end

  // read data captured with the request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_q <= 32'h00000000;
    end else if (req) begin
      if (hit_ctrl) begin
        dat_q <= {16'h0000, ctrl};
      end else if (hit_stat) begin
        dat_q <= {24'h000000, status};
      end else begin
        dat_q <= 32'h00000000;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = dat_q;

  // ==========================================================
  // checking helpers: main PLL ticks per bus period
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hp_ticks_q <= 4'h0;
      hp_steady_q <= 1'b0;
      mult_q <= 3'h1;
    end else begin
      mult_q <= mult;
      if (bus_edge) begin
        hp_ticks_q <= 4'h1;
        hp_steady_q <= manual_rst_n;
      end else if (pll_tick_d && hp_ticks_q != 4'hf) begin
        hp_ticks_q <= hp_ticks_q + 4'h1;
      end
      if (mult_q != mult || !manual_rst_n) begin
        hp_steady_q <= 1'b0;
      end
    end
  end

  sequence s_bus_rise;
    bus_lvl_q && !bus_prev_q;
  endsequence

  sequence s_steady_period;
    hp_steady_q && valid_q && mult_q == mult && manual_rst_n
      && cnt_inc == period_q;
  endsequence

  a_pll_ratio: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_bus_rise and s_steady_period
      |-> hp_ticks_q == {1'b0, mult})
    else $error("main PLL ticks per bus period differ from multiplier");
  a_edge_align: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_bus_rise ##0 manual_rst_n |=> main_pll_tick)
    else $error("main PLL tick not aligned to bus edge");
  a_pin_driven: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_q == MODE_EXT || mode_q == MODE_XTAL
      |=> bus_clock_pin_oe && bus_clock_pin_o == $past(shaped_q))
    else $error("bus clock pin not driven in mode 0 or 2");
  a_pin_input: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_q == MODE_PIN ##1 mode_q == MODE_PIN
      |-> !bus_clock_pin_oe && !shaped_q)
    else $error("bus clock pin driven or shaping on in mode 7");
  a_src_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_q == MODE_XTAL ##1 mode_q == MODE_XTAL
      |-> shaped_q == $past(crystal_osc_input))
    else $error("crystal not selected in mode 2");
  a_core_from_pll: assert property (@(posedge sys_clk) disable iff (!rst_n)
    core_clk_en |-> $past(main_pll_tick))
    else $error("core enable without a main PLL tick");
  a_per_from_pll: assert property (@(posedge sys_clk) disable iff (!rst_n)
    periph_clk_en |-> $past(main_pll_tick))
    else $error("peripheral enable without a main PLL tick");
  a_mode_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    status[ST_MODE_BAD] |-> mode_q inside {3'h1, 3'h3, 3'h4, 3'h5, 3'h6})
    else $error("mode flag set for a supported mode");
  a_bus_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req |=> (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o))
    else $error("bus answer missing or held");
endmodule // cmrs_clock_top

// *** design/cmrs_freq_reg.sv ***
// frequency control register storage, power-on reset only
// assumes the caller decodes the bus and qualifies the write
`timescale 1ns/1ps
module cmrs_freq_reg
  import cmrs_pkg::*;
(
  // clock and power-on reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // stored value
  output logic [15:0] value_q
);
  logic wrote_q;

  // only power-on reset loads it; manual reset never reaches here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= FREQ_CTRL_RESET;
    end else if (wr_en) begin
      value_q <= (wr_data & FREQ_CTRL_WMASK) | FREQ_CTRL_ONES;
    end
  end

  // helper: a write has happened since power-on
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrote_q <= 1'b0;
    end else if (wr_en) begin
      wrote_q <= 1'b1;
    end
  end

  a_reset_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wrote_q |-> value_q == FREQ_CTRL_RESET)
    else $error("register lost its power-on value");
  a_write_lands: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_en |=> value_q[15:13] == $past(wr_data[15:13])
      && value_q[5:0] == $past(wr_data[5:0]))
    else $error("write did not land in the fields");
  a_reserved_fixed: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (value_q & ~FREQ_CTRL_WMASK) == FREQ_CTRL_ONES)
    else $error("reserved bits changed");
endmodule // cmrs_freq_reg

// *** design/cmrs_pkg.sv ***
// constants, types and decode helpers of the clock mode and ratio select
// assumes a 10 MHz system clock and a classic Wishbone register bus
package cmrs_pkg;
  // ==========================================================
  // register map
  localparam logic [31:0] FREQ_CTRL_ADDR = 32'hffffff80;
  localparam logic [31:0] CLK_STATUS_ADDR = 32'hffffff90;
  localparam logic [15:0] FREQ_CTRL_RESET = 16'h0102;
  localparam logic [15:0] FREQ_CTRL_WMASK = 16'he03f;
  localparam logic [15:0] FREQ_CTRL_ONES = 16'h0100;
  // ==========================================================
  // field positions
  localparam int MULT_HI = 15;
  localparam int MULT_MID = 5;
  localparam int MULT_LO = 4;
  localparam int CORE_HI = 14;
  localparam int CORE_MID = 3;
  localparam int CORE_LO = 2;
  localparam int PER_HI = 13;
  localparam int PER_MID = 1;
  localparam int PER_LO = 0;
  // status register bits
  localparam int ST_MODE_LO = 0;
  localparam int ST_MODE_BAD = 3;
  localparam int ST_SET_BAD = 4;
  localparam int ST_SHAPE_ON = 5;
  localparam int ST_PIN_OUT = 6;
  localparam int ST_LOCKED = 7;
  // ==========================================================
  // modes, ratio codes, timing
  localparam logic [2:0] MODE_EXT = 3'h0;
  localparam logic [2:0] MODE_XTAL = 3'h2;
  localparam logic [2:0] MODE_PIN = 3'h7;
  localparam logic [2:0] CODE_X1 = 3'h0;
  localparam logic [2:0] CODE_X2 = 3'h1;
  localparam logic [2:0] CODE_X3 = 3'h4;
  localparam logic [2:0] CODE_X4 = 3'h2;
  localparam int PERIOD_W = 16;
  localparam logic [PERIOD_W-1:0] PERIOD_MIN = 16'h0005;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 16'hffff;
  typedef logic [2:0] cmrs_ratio_t;

  // ratio code to count 1..4
  function automatic cmrs_ratio_t cmrs_ratio(input logic [2:0] code);
    case (code)
      CODE_X2: return 3'h2;
      CODE_X3: return 3'h3;
      CODE_X4: return 3'h4;
      default: return 3'h1;
    endcase
  endfunction

  // gather a three-bit split field
  function automatic logic [2:0] cmrs_field(input logic [15:0] r,
      input int hi, input int mid, input int lo);
    return {r[hi], r[mid], r[lo]};
  endfunction

  // register value permitted in this mode
  function automatic logic cmrs_legal(input logic [2:0] mode,
      input logic [15:0] v);
    case (v)
      16'h0100, 16'h0101, 16'h0102, 16'h0111, 16'h0112, 16'h0115,
      16'h0116, 16'h0122, 16'h0126, 16'h012a, 16'ha100, 16'he100,
      16'he101: return 1'b1;
      16'ha101: return mode != MODE_PIN;
      default: return 1'b0;
    endcase
  endfunction
endpackage

// *** design/cmrs_ratio_div.sv ***
// ratio divider: one enable pulse per 1..4 main PLL ticks
// assumes ticks are single-cycle pulses of the system clock
`timescale 1ns/1ps
module cmrs_ratio_div
  import cmrs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // tick carrier
  cmrs_tick_if.div t
);
  logic [2:0] cnt_q;
  logic [2:0] code_q;
  logic en_q;
  cmrs_ratio_t ratio;
  logic [3:0] gap_q;
  logic steady_q;

  assign ratio = cmrs_ratio(t.code);
  assign t.en = en_q;

  // count ticks, restart at once on a new ratio
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      code_q <= 3'h0;
      en_q <= 1'b0;
    end else begin
      code_q <= t.code;
      en_q <= 1'b0;
      if (t.clr || code_q != t.code) begin
        cnt_q <= 3'h0;
      end else if (t.tick) begin
        if (cnt_q + 3'h1 >= ratio) begin
          cnt_q <= 3'h0;
          en_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 3'h1;
        end
      end
    end
  end

  // helper: ticks seen since the last pulse
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 4'h0;
      steady_q <= 1'b0;
    end else begin
      if (en_q) begin
        gap_q <= {3'h0, t.tick};
        steady_q <= 1'b1;
      end else if (t.tick && gap_q != 4'hf) begin
        gap_q <= gap_q + 4'h1;
      end
      if (t.clr || code_q != t.code) begin
        steady_q <= 1'b0;
      end
    end
  end

  sequence s_pulse_ready;
    steady_q && (code_q == t.code) && !t.clr;
  endsequence

  a_div_spacing: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pulse_ready ##0 en_q |-> gap_q == {1'b0, ratio})
    else $error("divider pulse spacing differs from ratio");
endmodule // cmrs_ratio_div

// *** design/cmrs_tick_if.sv ***
// tick carrier between the main PLL model and one ratio divider
// assumes one system clock domain
`timescale 1ns/1ps
interface cmrs_tick_if;
  logic tick;
  logic clr;
  logic [2:0] code;
  logic en;
  modport src (output tick, output clr, output code, input en);
  modport div (input tick, input clr, input code, output en);
endinterface

// *** testbench/cmrs_src_model.sv ***
// source clock model: external oscillator, crystal or clock generator
// assumes sys_clk runs far faster than the source; idles low when off
`timescale 1ns/1ps
module cmrs_src_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic [3:0] half,
  // source clock level
  output logic clk_o
);
  logic [3:0] cnt_q;

  // ==========================================================
  // toggle every half cycles, stand still low while stopped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      clk_o <= 1'b0;
    end else if (!run) begin
      cnt_q <= 4'h0;
      clk_o <= 1'b0;
    end else if (cnt_q == half - 4'h1) begin
      cnt_q <= 4'h0;
      clk_o <= !clk_o;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // cmrs_src_model

// *** testbench/tb_top.sv ***
// self-checking bench for the clock mode and ratio select
// assumes cmrs_src_model as clock source and a 10 MHz sys_clk
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top
  import cmrs_pkg::*;
;
  // ==========================================================
  // signals
  logic sys_clk, rst_n, manual_rst_n, run, src_clk, ext_in, xtal_in;
  logic pin_in, pin_o, pin_oe, tick, core_en, per_en;
  logic [2:0] strap;
  logic wb_cyc, wb_stb, wb_we, wb_ack, wb_err;
  logic [31:0] wb_adr, wb_wdat, wb_rdat;
  logic [3:0] wb_sel;
  int errors = 0;
  int cmp_count = 0;
  // only permitted values within the frequency limits
  logic [15:0] vals [9] = '{16'h0122, 16'ha100, 16'h0115, 16'h0100,
    16'h0102, 16'h0111, 16'h0126, 16'h012a, 16'he100};

  // source routing; the bus pin is pulled low when nobody drives it
  assign ext_in = (strap != 3'h2 && strap != 3'h7) ? src_clk : 1'b0;
  assign xtal_in = (strap == 3'h2) ? src_clk : 1'b0;
  assign pin_in = pin_oe ? pin_o : ((strap == 3'h7) ? src_clk : 1'b0);

  // clock, period 100 ns
  always #50 sys_clk = !sys_clk;

  cmrs_src_model src (.sys_clk(sys_clk), .rst_n(rst_n), .run(run),
    .half(4'h4), .clk_o(src_clk));

  cmrs_clock_top DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .manual_rst_n(manual_rst_n), .clock_mode_pin_0(strap[0]),
    .clock_mode_pin_1(strap[1]), .clock_mode_pin_2(strap[2]),
    .external_clock_input(ext_in), .crystal_osc_input(xtal_in),
    .bus_clock_pin_i(pin_in), .bus_clock_pin_o(pin_o),
    .bus_clock_pin_oe(pin_oe), .main_pll_tick(tick),
    .core_clk_en(core_en), .periph_clk_en(per_en), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .wb_err_o(wb_err));

  // ==========================================================
  // helpers
  function automatic int rat(input logic [2:0] c);
    case (c)
      3'h1: return 2;
      3'h4: return 3;
      3'h2: return 4;
      default: return 1;
    endcase
  endfunction

  // one classic wishbone cycle, held until ack or err; watchdog ends hangs
  task automatic wb(input logic we, input logic [31:0] adr,
      input logic [31:0] wd, input logic [3:0] sel,
      output logic [31:0] rd, output logic er);
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_wdat <= wd;
    do begin
      @(posedge sys_clk);
    end while (wb_ack !== 1'b1 && wb_err !== 1'b1);
    rd = wb_rdat;
    er = wb_err;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic finish_test;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic e;
    wb(1'b0, FREQ_CTRL_ADDR, 32'h0, 4'hf, d, e);
    `CHK(d, 32'h00000102)
    wb(1'b1, FREQ_CTRL_ADDR, 32'hffffffff, 4'hf, d, e);
    wb(1'b0, FREQ_CTRL_ADDR, 32'h0, 4'hf, d, e);
    `CHK(d, 32'h0000e13f)
    wb(1'b1, FREQ_CTRL_ADDR, 32'h0, 4'hc, d, e);
    wb(1'b0, FREQ_CTRL_ADDR, 32'h0, 4'hf, d, e);
    `CHK(d, 32'h0000e13f)
    wb(1'b0, 32'hffffff84, 32'h0, 4'hf, d, e);
    `CHK(e, 1'b1)
  endtask

  // program one value, then count edges over twelve bus periods
  task automatic t_ratio(input logic [15:0] v);
    logic [31:0] d;
    logic e, prev;
    int m, c, p, nt, nc, np, nb;
    m = rat({v[15], v[5], v[4]});
    c = rat({v[14], v[3], v[2]});
    p = rat({v[13], v[1], v[0]});
    nt = 0;
    nc = 0;
    np = 0;
    nb = 0;
    wb(1'b1, FREQ_CTRL_ADDR, {16'h0, v}, 4'hf, d, e);
    wb(1'b0, CLK_STATUS_ADDR, 32'h0, 4'hf, d, e);
    `CHK(d[ST_SET_BAD], 1'b0)
    repeat (48) @(posedge sys_clk);
    prev = pin_o;
    repeat (96) begin
      @(posedge sys_clk);
      nt += (tick === 1'b1);
      nc += (core_en === 1'b1);
      np += (per_en === 1'b1);
      nb += (pin_o === 1'b1 && prev === 1'b0);
      prev = pin_o;
    end
    `CHK(nt, 12 * m)
    `CHK(nc, 12 * m / c)
    `CHK(np, 12 * m / p)
    `CHK(nb, (strap == 3'h7) ? 0 : 12)
  endtask

  task automatic t_mode(input logic [2:0] md, input int n);
    logic [31:0] d;
    logic e;
    @(posedge sys_clk);
    strap <= md;
    run <= 1'b1;
    repeat (40) @(posedge sys_clk);
    wb(1'b0, CLK_STATUS_ADDR, 32'h0, 4'hf, d, e);
    `CHK(d[2:0], md)
    `CHK(d[ST_MODE_BAD], !(md inside {3'h0, 3'h2, 3'h7}))
    `CHK(d[ST_SHAPE_ON], md != 3'h7)
    `CHK(d[ST_PIN_OUT], md != 3'h7)
    `CHK(pin_oe, md != 3'h7)
    for (int i = 0; i < n; i++) begin
      t_ratio(vals[i]);
    end
    wb(1'b1, FREQ_CTRL_ADDR, 32'h0000a101, 4'hf, d, e);
    wb(1'b0, CLK_STATUS_ADDR, 32'h0, 4'hf, d, e);
    `CHK(d[ST_SET_BAD], md == 3'h7)
  endtask

  task automatic t_resets;
    logic [31:0] d;
    logic e;
    wb(1'b1, FREQ_CTRL_ADDR, 32'h00000122, 4'hf, d, e);
    @(posedge sys_clk);
    manual_rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    manual_rst_n <= 1'b1;
    wb(1'b0, FREQ_CTRL_ADDR, 32'h0, 4'hf, d, e);
    `CHK(d, 32'h00000122)
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    wb(1'b0, FREQ_CTRL_ADDR, 32'h0, 4'hf, d, e);
    `CHK(d, 32'h00000102)
  endtask

  // ==========================================================
  // watchdog, about four times the expected run
  initial begin
    #1000000;
    errors++;
    finish_test();
  end

  // main sequence
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    manual_rst_n = 1'b1;
    run = 1'b0;
    strap = 3'h0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 32'h0;
    wb_sel = 4'h0;
    wb_wdat = 32'h0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_mode(3'h0, 9);
    t_mode(3'h2, 3);
    t_mode(3'h7, 3);
    t_mode(3'h1, 0);
    t_resets();
    finish_test();
  end
endmodule // tb_top
